// ==== hdl/interval_timer_pkg.sv ====
/*
 * Shared constants and types of the 12-bit interval timer: register offsets,
 * field positions, reset values, bus responses and the control word layout.
 * Assumes a 32-bit AXI4-Lite register bus with 8 address bits decoded.
 */
package interval_timer_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CLOCK_ENABLE = 8'h00;
    localparam logic [7:0] OFF_REQUEST_FLAGS = 8'h04;
    localparam logic [7:0] OFF_MASK_FLAGS = 8'h08;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h0C;
    localparam logic [7:0] OFF_PERIPH_RESET = 8'h10;
    localparam logic [7:0] OFF_PRIORITY = 8'h14;
    localparam logic [7:0] OFF_CLOCK_SELECT = 8'h18;
    localparam logic [7:0] OFF_SPEED_CONTROL = 8'h1C;
    localparam logic [7:0] OFF_COUNT = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SUPPLY_BIT = 7;
    localparam int FLAG_BIT = 1;
    localparam int MASK_BIT = 1;
    localparam int PERIPH_RESET_BIT = 7;
    localparam int SLOW_SEL_BIT = 4;
    localparam int PRIO_HI_BIT = 1;
    localparam int PRIO_LO_BIT = 0;
    localparam int CMP_W = 12;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_TIMER_CONTROL = 16'h0FFF;
    localparam logic RST_SUPPLY = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_PERIPH_RESET = 1'b0;
    localparam logic RST_SLOW_SEL = 1'b0;
    localparam logic [1:0] RST_PRIORITY = 2'h3;
    localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] CLOCK_SELECT_SLOW_OSC = 8'h00;
    localparam logic [1:0] PRIO_LOWEST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic run;
        logic [2:0] unused;
        logic [CMP_W-1:0] compare;
    } timer_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } bus_write_t;

endpackage : interval_timer_pkg

// ==== hdl/slow_clock_sync.sv ====
/*
 * Brings the free-running slow oscillator into the bus clock domain and
 * marks each accepted rising edge with a one-cycle pulse.
 * Assumes the slow clock runs far below half the bus clock rate.
 */
`timescale 1ns/1ps
module slow_clock_sync
    import interval_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic rise
);

    logic [2:0] stage;
    logic level;
    logic next_level;

    // Level accepted only once stages two and three agree
    always_comb begin
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage <= 3'h0;
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            stage <= {stage[1:0], async_in};
            level <= next_level;
            rise <= next_level & ~level;
        end
    end

endmodule : slow_clock_sync

// ==== hdl/interval_counter.sv ====
/*
 * 12-bit up-counter of count-clock events with wrap at the compare value.
 * Assumes tick is a one-cycle pulse already gated by supply and selection.
 */
`timescale 1ns/1ps
module interval_counter
    import interval_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic tick,
    input wire logic [CMP_W-1:0] compare,
    output logic [CMP_W-1:0] count,
    output logic match
);

    logic [CMP_W-1:0] next_count;
    logic next_match;

    always_comb begin
        next_count = count;
        next_match = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (tick) begin
            if (count == compare) begin // RQ4 RQ13
                next_count = '0;
                next_match = 1'b1;
            end else begin
                next_count = count + 12'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            match <= 1'b0;
        end else begin
            count <= next_count;
            match <= next_match;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (tick && !clear && count == compare) |=> match && count == '0;
    endproperty
    a_wrap: assert property (p_wrap) // RQ4
        else $error("no wrap at compare value");

    property p_step;
        @(posedge aclk) disable iff (!aresetn)
        (tick && !clear && count != compare)
            |=> !match && count == $past(count) + 12'h001;
    endproperty
    a_step: assert property (p_step) // RQ13
        else $error("count did not advance by one");

endmodule : interval_counter

// ==== hdl/interval_timer_12bit.sv ====
/*
 * 12-bit interval timer with AXI4-Lite registers, clock supply gate,
 * peripheral reset, request flag, mask, priority and one interrupt line.
 * Assumes the slow oscillator arrives asynchronously on low_speed_osc_clock.
 */
// The register offsets and the AXI4-Lite slave port were left to the implementer.
// Functional notes
// RQ1 - Count clock reaches the timer only while the clock supply bit is one.
// RQ2 - Run bit zero stops and clears the count; run bit one counts.
// RQ3 - Software writes a nonzero 12-bit compare value in control bits 11-0.
// RQ4 - Interval interrupt repeats every compare plus one count clock cycles.
// RQ5 - Request flag set by an interval event; software clears it writing zero.
// RQ6 - Mask one blocks servicing; the flag still records requests.
// RQ7 - Software pulses the peripheral reset bit before enabling clock supply.
// RQ8 - Software stops the timer, masks and clears the flag before setup.
// RQ9 - Both priority bits set give level three, the lowest priority.
// RQ10 - Clock select register zero takes the slow oscillator as count clock.
// RQ11 - For five milliseconds software loads compare 004AH while stopped.
// RQ12 - Speed control bit one routes the slow oscillator to the timer.
// RQ13 - Up-counter wraps to zero at compare and flags one event then.
`timescale 1ns/1ps
module interval_timer_12bit
    import interval_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_speed_osc_clock,
    output logic interval_interrupt,
    output logic [1:0] irq_priority
);

    // ------------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------------
    bus_write_t wr, next_wr;
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write, write_hit;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    timer_ctrl_t ctrl, next_ctrl;
    logic timer_clock_supply_enable, next_supply;
    logic interval_irq_request_flag, next_flag;
    logic interval_irq_mask, next_mask;
    logic timer_peripheral_reset, next_periph_reset;
    logic interval_irq_priority_hi, interval_irq_priority_lo;
    logic [1:0] next_priority;
    logic [7:0] timer_clock_select_reg, next_clock_select;
    logic slow_osc_timer_clock_select, next_slow_sel, next_irq;

    // ------------------------------------------------------------------
    // Count path
    // ------------------------------------------------------------------
    logic slow_rise, tick_enable, count_tick, count_clear, match;
    logic [CMP_W-1:0] count;

    slow_clock_sync u_sync (
        .aclk(aclk), .aresetn(aresetn),
        .async_in(low_speed_osc_clock), .rise(slow_rise)
    );

    assign tick_enable = timer_clock_supply_enable // RQ1
        && slow_osc_timer_clock_select // RQ12
        && (timer_clock_select_reg == CLOCK_SELECT_SLOW_OSC); // RQ10
    assign count_tick = slow_rise && tick_enable;
    assign count_clear = !ctrl.run || timer_peripheral_reset; // RQ2

    interval_counter u_counter (
        .aclk(aclk), .aresetn(aresetn), .clear(count_clear), .tick(count_tick),
        .compare(ctrl.compare), .count(count), .match(match)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------
    always_comb begin
        next_wr = wr;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_wr.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_wr.data = s_axi_wdata;
            next_wr.strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        do_write = aw_full && w_full && !s_axi_bvalid;
        case (wr.addr)
            OFF_CLOCK_ENABLE, OFF_REQUEST_FLAGS, OFF_MASK_FLAGS,
            OFF_TIMER_CONTROL, OFF_PERIPH_RESET, OFF_PRIORITY,
            OFF_CLOCK_SELECT, OFF_SPEED_CONTROL, OFF_COUNT: write_hit = 1'b1;
            default: write_hit = 1'b0;
        endcase
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = write_hit ? RESP_OKAY : RESP_SLVERR;
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFF_CLOCK_ENABLE: next_rdata[SUPPLY_BIT] = timer_clock_supply_enable;
                OFF_REQUEST_FLAGS: next_rdata[FLAG_BIT] = interval_irq_request_flag;
                OFF_MASK_FLAGS: next_rdata[MASK_BIT] = interval_irq_mask;
                OFF_TIMER_CONTROL: next_rdata[15:0] = {ctrl.run, 3'h0, ctrl.compare};
                OFF_PERIPH_RESET: next_rdata[PERIPH_RESET_BIT] = timer_peripheral_reset;
                OFF_PRIORITY: next_rdata[1:0] = irq_priority;
                OFF_CLOCK_SELECT: next_rdata[7:0] = timer_clock_select_reg;
                OFF_SPEED_CONTROL: next_rdata[SLOW_SEL_BIT] = slow_osc_timer_clock_select;
                OFF_COUNT: next_rdata[CMP_W-1:0] = count;
                default: next_rresp = RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr <= '0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            wr <= next_wr;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------------
    // Registers, request flag and interrupt line
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_supply = timer_clock_supply_enable;
        next_flag = interval_irq_request_flag;
        next_mask = interval_irq_mask;
        next_periph_reset = timer_peripheral_reset;
        next_priority = {interval_irq_priority_hi, interval_irq_priority_lo};
        next_clock_select = timer_clock_select_reg;
        next_slow_sel = slow_osc_timer_clock_select;
        if (do_write) begin
            case (wr.addr)
                OFF_CLOCK_ENABLE: if (wr.strb[0]) next_supply = wr.data[SUPPLY_BIT];
                OFF_REQUEST_FLAGS: if (wr.strb[0] && !wr.data[FLAG_BIT]) next_flag = 1'b0;
                OFF_MASK_FLAGS: if (wr.strb[0]) next_mask = wr.data[MASK_BIT];
                OFF_TIMER_CONTROL: begin
                    if (wr.strb[0]) next_ctrl.compare[7:0] = wr.data[7:0];
                    if (wr.strb[1]) begin
                        next_ctrl.compare[CMP_W-1:8] = wr.data[CMP_W-1:8];
                        next_ctrl.run = wr.data[15];
                    end
                end
                OFF_PERIPH_RESET: begin
                    if (wr.strb[0]) next_periph_reset = wr.data[PERIPH_RESET_BIT];
                end
                OFF_PRIORITY: if (wr.strb[0]) next_priority = wr.data[1:0];
                OFF_CLOCK_SELECT: if (wr.strb[0]) next_clock_select = wr.data[7:0];
                OFF_SPEED_CONTROL: if (wr.strb[0]) next_slow_sel = wr.data[SLOW_SEL_BIT];
                default: next_ctrl = ctrl;
            endcase
        end
        // Peripheral reset holds the timer in its reset state
        if (timer_peripheral_reset) begin
            next_ctrl = RST_TIMER_CONTROL;
            next_flag = RST_FLAG;
        end
        // Event beats a clear in the same cycle
        if (match) begin
            next_flag = 1'b1; // RQ5 RQ13
        end
        next_irq = next_flag && !next_mask; // RQ6
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= RST_TIMER_CONTROL;
            timer_clock_supply_enable <= RST_SUPPLY;
            interval_irq_request_flag <= RST_FLAG;
            interval_irq_mask <= RST_MASK;
            timer_peripheral_reset <= RST_PERIPH_RESET;
            interval_irq_priority_hi <= RST_PRIORITY[PRIO_HI_BIT];
            interval_irq_priority_lo <= RST_PRIORITY[PRIO_LO_BIT];
            irq_priority <= RST_PRIORITY;
            timer_clock_select_reg <= RST_CLOCK_SELECT;
            slow_osc_timer_clock_select <= RST_SLOW_SEL;
            interval_interrupt <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            timer_clock_supply_enable <= next_supply;
            interval_irq_request_flag <= next_flag;
            interval_irq_mask <= next_mask;
            timer_peripheral_reset <= next_periph_reset;
            interval_irq_priority_hi <= next_priority[1];
            interval_irq_priority_lo <= next_priority[0];
            irq_priority <= next_priority; // RQ9
            timer_clock_select_reg <= next_clock_select;
            slow_osc_timer_clock_select <= next_slow_sel;
            interval_interrupt <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_supply_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!timer_clock_supply_enable && !count_clear) |=> $stable(count);
    endproperty
    a_supply_gate: assert property (p_supply_gate) // RQ1
        else $error("count moved without clock supply");

    property p_stop_clears;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl.run |=> (count == '0) && !match;
    endproperty
    a_stop_clears: assert property (p_stop_clears) // RQ2
        else $error("stopped timer kept a count");

    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn)
        match |=> interval_irq_request_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) // RQ5
        else $error("request flag not set by event");

    property p_masked_records;
        @(posedge aclk) disable iff (!aresetn)
        (match && next_mask) |=> interval_irq_request_flag ##0 !interval_interrupt;
    endproperty
    a_masked_records: assert property (p_masked_records) // RQ6
        else $error("mask lost the flag or leaked interrupt");

    property p_irq_level;
        @(posedge aclk) disable iff (!aresetn)
        interval_interrupt == (interval_irq_request_flag && !interval_irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) // RQ6
        else $error("interrupt line disagrees with flag and mask");

    property p_select_gate;
        @(posedge aclk) disable iff (!aresetn)
        (timer_clock_select_reg != CLOCK_SELECT_SLOW_OSC && !count_clear)
            |=> $stable(count);
    endproperty
    a_select_gate: assert property (p_select_gate) // RQ10
        else $error("count moved with another clock selected");

    property p_speed_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!slow_osc_timer_clock_select && !count_clear) |=> $stable(count);
    endproperty
    a_speed_gate: assert property (p_speed_gate) // RQ12
        else $error("count moved without slow oscillator routed");

    property p_prio;
        @(posedge aclk) disable iff (!aresetn)
        (interval_irq_priority_hi && interval_irq_priority_lo)
            |-> irq_priority == PRIO_LOWEST;
    endproperty
    a_prio: assert property (p_prio) // RQ9
        else $error("priority bits not shown as lowest level");

    property p_bhold;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");

    c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) match);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(interval_interrupt));
    c_write: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);

endmodule : interval_timer_12bit

// ==== test/interval_timer_12bit_bench.sv ====
/*
 * Self-checking bench of the 12-bit interval timer: AXI4-Lite register
 * tasks, slow oscillator edges, gating, wrap, flag, mask and priority.
 * Assumes the design package and the timer top are compiled first.
 */
`timescale 1ns/1ps
module interval_timer_12bit_bench;
    import interval_timer_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rd_data;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, osc = 1'b0, irq;
    logic [1:0] bresp, rresp, rd_resp, wr_resp, prio;
    logic [31:0] rdata;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] gate_sup [3] = '{8'h00, 8'h80, 8'h80};
    logic [7:0] gate_spd [3] = '{8'h10, 8'h00, 8'h10};
    logic [7:0] gate_sel [3] = '{8'h00, 8'h00, 8'h01};

    interval_timer_12bit u_interval_timer_12bit (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_speed_osc_clock(osc),
        .interval_interrupt(irq), .irq_priority(prio)
    );

    initial begin
        forever #25 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        wr_resp = bresp;
        bready <= 1'b0;
        if (n >= 100) check("write answer", 32'h1, 32'h0);
        @(posedge aclk);
    endtask : axi_write

    task axi_read(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        if (n >= 100) check("read answer", 32'h1, 32'h0);
        @(posedge aclk);
    endtask : axi_read

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        axi_read(a);
        check(name, rd_data, exp);
        check("read resp", {30'h0, rd_resp}, {30'h0, RESP_OKAY});
    endtask : rd_chk

    task osc_edges(input int n);
        repeat (n) begin
            osc <= 1'b1;
            repeat (4) @(posedge aclk);
            osc <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        repeat (3) @(posedge aclk);
    endtask : osc_edges

    // ----------------------------------------------------------------
    // Timeout
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(OFF_TIMER_CONTROL, 32'h0FFF, "control reset");
        rd_chk(OFF_MASK_FLAGS, 32'h02, "mask reset");
        rd_chk(OFF_PRIORITY, 32'h03, "priority reset");
        check("irq_priority", {30'h0, prio}, 32'h3);
        axi_read(8'h24);
        check("unmapped rresp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
        axi_write(8'h24, 32'h0);
        check("unmapped bresp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
        $display("test reset values done");
        axi_write(OFF_PERIPH_RESET, 32'h80);
        axi_write(OFF_PERIPH_RESET, 32'h00);
        axi_write(OFF_CLOCK_ENABLE, 32'h80);
        axi_write(OFF_TIMER_CONTROL, 32'h0000);
        axi_write(OFF_MASK_FLAGS, 32'h02);
        axi_write(OFF_REQUEST_FLAGS, 32'h00);
        axi_write(OFF_PRIORITY, 32'h00);
        check("irq_priority low", {30'h0, prio}, 32'h0);
        axi_write(OFF_PRIORITY, 32'h03);
        check("irq_priority lowest", {30'h0, prio}, {30'h0, PRIO_LOWEST});
        axi_write(OFF_CLOCK_SELECT, 32'h00);
        axi_write(OFF_SPEED_CONTROL, 32'h10);
        axi_write(OFF_TIMER_CONTROL, 32'h0003);
        axi_write(OFF_TIMER_CONTROL, 32'h8003);
        osc_edges(3);
        rd_chk(OFF_COUNT, 32'h3, "count at compare");
        rd_chk(OFF_REQUEST_FLAGS, 32'h0, "flag before wrap");
        osc_edges(1);
        rd_chk(OFF_COUNT, 32'h0, "count wrapped");
        rd_chk(OFF_REQUEST_FLAGS, 32'h2, "flag after wrap");
        check("irq while masked", {31'h0, irq}, 32'h0);
        axi_write(OFF_MASK_FLAGS, 32'h00);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        axi_write(OFF_REQUEST_FLAGS, 32'h02);
        check("flag write one", {31'h0, irq}, 32'h1);
        axi_write(OFF_REQUEST_FLAGS, 32'h00);
        check("irq cleared", {31'h0, irq}, 32'h0);
        osc_edges(2);
        axi_write(OFF_TIMER_CONTROL, 32'h0003);
        rd_chk(OFF_COUNT, 32'h0, "count cleared by stop");
        $display("test wrap and flag done");
        for (int i = 0; i < 3; i++) begin
            axi_write(OFF_CLOCK_ENABLE, {24'h0, gate_sup[i]});
            axi_write(OFF_SPEED_CONTROL, {24'h0, gate_spd[i]});
            axi_write(OFF_CLOCK_SELECT, {24'h0, gate_sel[i]});
            axi_write(OFF_TIMER_CONTROL, 32'h8003);
            osc_edges(2);
            rd_chk(OFF_COUNT, 32'h0, "gated count");
            axi_write(OFF_TIMER_CONTROL, 32'h0003);
        end
        $display("test clock gating done");
        axi_write(OFF_CLOCK_ENABLE, 32'h80);
        axi_write(OFF_SPEED_CONTROL, 32'h10);
        axi_write(OFF_CLOCK_SELECT, 32'h00);
        axi_write(OFF_TIMER_CONTROL, 32'h004A);
        rd_chk(OFF_TIMER_CONTROL, 32'h004A, "compare loaded");
        axi_write(OFF_TIMER_CONTROL, 32'h804A);
        osc_edges(74);
        rd_chk(OFF_COUNT, 32'h4A, "long count");
        check("irq early", {31'h0, irq}, 32'h0);
        osc_edges(1);
        check("irq on period", {31'h0, irq}, 32'h1);
        osc_edges(2);
        axi_write(OFF_PERIPH_RESET, 32'h80);
        rd_chk(OFF_COUNT, 32'h0, "count in periph reset");
        rd_chk(OFF_TIMER_CONTROL, 32'h0FFF, "control in periph reset");
        check("irq in periph reset", {31'h0, irq}, 32'h0);
        axi_write(OFF_PERIPH_RESET, 32'h00);
        $display("test long interval done");
        test_done();
    end

endmodule : interval_timer_12bit_bench
